// ===== design/cps_cfg.svh
// timing and width constants of the charger protection sequencer
`ifndef CPS_CFG_SVH
`define CPS_CFG_SVH
`define CPS_CLK_MHZ 250
`define CPS_PWRUP_DELAY_MS 10
`define CPS_OC_QUAL_US 170
`define CPS_OC_OFF_MS 40
`define CPS_BOV_BLANK_US 180
`define CPS_SS_US 1000
`define CPS_PWRUP_CYC (`CPS_PWRUP_DELAY_MS * 1000 * `CPS_CLK_MHZ)
`define CPS_OC_QUAL_CYC (`CPS_OC_QUAL_US * `CPS_CLK_MHZ)
`define CPS_OC_OFF_CYC (`CPS_OC_OFF_MS * 1000 * `CPS_CLK_MHZ)
`define CPS_BOV_BLANK_CYC (`CPS_BOV_BLANK_US * `CPS_CLK_MHZ)
`define CPS_SS_CYC (`CPS_SS_US * `CPS_CLK_MHZ)
`define CPS_EVT_CNT_W 4
`define CPS_RAMP_W 8
`define CPS_TMR_W 24
`endif

// ===== design/cps_pkg.sv
// types of the charger protection sequencer
package cps_pkg;
  typedef enum logic [4:0] {
    CPS_ST_WAIT = 5'h01,
    CPS_ST_RAMP = 5'h02,
    CPS_ST_ON = 5'h04,
    CPS_ST_OFF = 5'h08,
    CPS_ST_LOCK = 5'h10
  } cps_state_t;
endpackage

// ===== design/cps_flag_if.sv
// interface carrying synchronised comparator flags and qualified events
`timescale 1ns/100ps
interface cps_flag_if;
  logic ov;
  logic oc_raw;
  logic bov_raw;
  logic ot;
  logic oc_evt;
  logic oc_active;
  logic bov_evt;
  logic bov_active;
  modport src (output ov, output oc_raw, output bov_raw, output ot);
  modport qual (input oc_raw, input bov_raw, output oc_evt, output oc_active, output bov_evt, output bov_active);
  modport sink (input ov, input ot, input oc_evt, input oc_active, input bov_evt, input bov_active);
endinterface // cps_flag_if

// ===== design/cps_qualify.sv
// qualification timers for overcurrent and battery overvoltage flags
`timescale 1ns/100ps
`include "cps_cfg.svh"
module cps_qualify
  import cps_pkg::*;
#(
  parameter int OC_QUAL_CYC = `CPS_OC_QUAL_CYC,
  parameter int BOV_BLANK_CYC = `CPS_BOV_BLANK_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic enable,
  cps_flag_if.qual flags
);
  localparam logic [`CPS_TMR_W-1:0] OC_LAST = `CPS_TMR_W'(OC_QUAL_CYC - 1);
  localparam logic [`CPS_TMR_W-1:0] BOV_LAST = `CPS_TMR_W'(BOV_BLANK_CYC - 1);
  logic [`CPS_TMR_W-1:0] oc_cnt_reg, oc_cnt_next, bov_cnt_reg, bov_cnt_next;
  logic oc_act_reg, oc_act_next, bov_act_reg, bov_act_next;
  logic oc_evt_reg, oc_evt_next, bov_evt_reg, bov_evt_next;

  // a flag must stay high for the full window; any dropout restarts it
  always_comb begin
    oc_cnt_next = oc_cnt_reg;
    oc_act_next = oc_act_reg;
    oc_evt_next = 1'b0;
    bov_cnt_next = bov_cnt_reg;
    bov_act_next = bov_act_reg;
    bov_evt_next = 1'b0;
    if (!enable || !flags.oc_raw) begin
      oc_cnt_next = '0;
      oc_act_next = 1'b0;
    end else if (!oc_act_reg) begin
      if (oc_cnt_reg == OC_LAST) begin
        oc_act_next = 1'b1;
        oc_evt_next = 1'b1;
      end else begin
        oc_cnt_next = oc_cnt_reg + 1'b1;
      end
    end
    if (!enable || !flags.bov_raw) begin
      bov_cnt_next = '0;
      bov_act_next = 1'b0;
    end else if (!bov_act_reg) begin
      if (bov_cnt_reg == BOV_LAST) begin
        bov_act_next = 1'b1;
        bov_evt_next = 1'b1;
      end else begin
        bov_cnt_next = bov_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oc_cnt_reg <= '0;
      oc_act_reg <= 1'b0;
      oc_evt_reg <= 1'b0;
      bov_cnt_reg <= '0;
      bov_act_reg <= 1'b0;
      bov_evt_reg <= 1'b0;
    end else begin
      oc_cnt_reg <= oc_cnt_next;
      oc_act_reg <= oc_act_next;
      oc_evt_reg <= oc_evt_next;
      bov_cnt_reg <= bov_cnt_next;
      bov_act_reg <= bov_act_next;
      bov_evt_reg <= bov_evt_next;
    end
  end

  assign flags.oc_evt = oc_evt_reg;
  assign flags.oc_active = oc_act_reg;
  assign flags.bov_evt = bov_evt_reg;
  assign flags.bov_active = bov_act_reg;
endmodule // cps_qualify

// ===== design/cps_sync.sv
// two-flop synchronisers for the comparator flags
`timescale 1ns/100ps
module cps_sync
  import cps_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] raw,
  cps_flag_if.src flags
);
  logic [3:0] meta_reg, sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 4'h0;
      sync_reg <= 4'h0;
    end else begin
      meta_reg <= raw;
      sync_reg <= meta_reg;
    end
  end

  assign flags.ov = sync_reg[0];
  assign flags.oc_raw = sync_reg[1];
  assign flags.bov_raw = sync_reg[2];
  assign flags.ot = sync_reg[3];
endmodule // cps_sync

// ===== design/cps_sequencer.sv
// top of the charger protection sequencer: power-up, ramp, protection and lockout
`timescale 1ns/100ps
`include "cps_cfg.svh"
module cps_sequencer
  import cps_pkg::*;
#(
  parameter int PWRUP_CYC = `CPS_PWRUP_CYC,
  parameter int OC_OFF_CYC = `CPS_OC_OFF_CYC,
  parameter int SS_CYC = `CPS_SS_CYC,
  parameter int OC_QUAL_CYC = `CPS_OC_QUAL_CYC,
  parameter int BOV_BLANK_CYC = `CPS_BOV_BLANK_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic input_ov_comparator,
  input wire logic overcurrent_comparator,
  input wire logic battery_ov_comparator,
  input wire logic overtemp_flag,
  output logic switch_en,
  output logic [`CPS_RAMP_W-1:0] soft_start_level,
  output logic fault_n_output_o,
  output logic fault_n_output_oe,
  output logic locked_out
);
  localparam logic [`CPS_TMR_W-1:0] PWRUP_LAST = `CPS_TMR_W'(PWRUP_CYC - 1);
  localparam logic [`CPS_TMR_W-1:0] OC_OFF_LAST = `CPS_TMR_W'(OC_OFF_CYC - 1);
  localparam logic [`CPS_TMR_W-1:0] SS_STEP_LAST = `CPS_TMR_W'((SS_CYC >> `CPS_RAMP_W) - 1);
  localparam logic [`CPS_RAMP_W-1:0] RAMP_FULL = '1;
  localparam logic [`CPS_EVT_CNT_W-1:0] EVT_LAST = '1;

  // the switch conducts in these two states; shared by qualification, enable and fault
  function automatic logic cps_running(input cps_state_t s);
    return (s == CPS_ST_RAMP) || (s == CPS_ST_ON);
  endfunction

  cps_flag_if flags ();
  cps_state_t state_reg, state_next;
  logic [`CPS_TMR_W-1:0] tmr_reg, tmr_next;
  logic [`CPS_RAMP_W-1:0] ramp_reg, ramp_next;
  logic [1:0] evt_hit;
  logic [1:0] lock_now;
  logic [1:0] lock_soon;
  logic oc_hold_reg, oc_hold_next;
  logic en_reg, en_next, flt_reg, flt_next;
  logic lock_out_reg, lock_out_next;
  logic qual_enable;
  logic stop_now;

  // comparator flags come from the analog side, so resynchronise them
  cps_sync u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .raw({overtemp_flag, battery_ov_comparator, overcurrent_comparator, input_ov_comparator}),
    .flags(flags)
  );

  // qualification only runs while the switch is on or ramping
  assign qual_enable = cps_running(state_reg);

  cps_qualify #(.OC_QUAL_CYC(OC_QUAL_CYC), .BOV_BLANK_CYC(BOV_BLANK_CYC)) u_qual (
    .clk(clk),
    .arst_n(arst_n),
    .enable(qual_enable),
    .flags(flags)
  );

  // conditions that force the switch off immediately from any running state
  assign stop_now = flags.ov || flags.ot || flags.oc_evt || flags.bov_evt;

  // event kinds: bit 0 overcurrent, bit 1 battery overvoltage
  assign evt_hit = {flags.bov_evt, flags.oc_evt};

  // one saturating counter and lockout latch per event kind; only arst_n clears them
  for (genvar k = 0; k < 2; k++) begin : g_evt
    logic [`CPS_EVT_CNT_W-1:0] cnt_reg, cnt_next;
    logic lock_reg, lock_next;

    // the sixteenth event finds the count at fifteen and sets the latch
    always_comb begin
      cnt_next = cnt_reg;
      lock_next = lock_reg;
      if (evt_hit[k]) begin
        if (cnt_reg == EVT_LAST) begin
          lock_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
    end

    // a brown-out that stays above the reset threshold keeps the count
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        cnt_reg <= '0;
        lock_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_next;
        lock_reg <= lock_next;
      end
    end

    assign lock_now[k] = lock_reg;
    assign lock_soon[k] = lock_next;
  end

  // main sequence: wait, ramp, on, off period, lockout
  always_comb begin
    state_next = state_reg;
    tmr_next = tmr_reg;
    ramp_next = ramp_reg;
    oc_hold_next = oc_hold_reg;
    case (state_reg)
      CPS_ST_WAIT: begin
        ramp_next = '0;
        // input overvoltage, raw battery overvoltage or overtemperature restarts the full delay; overcurrent does not
        if (flags.ov || flags.bov_raw || flags.ot) begin
          tmr_next = '0;
        end else if (tmr_reg == PWRUP_LAST) begin
          tmr_next = '0;
          state_next = CPS_ST_RAMP;
        end else begin
          tmr_next = tmr_reg + 1'b1;
        end
      end
      CPS_ST_RAMP: begin
        if (stop_now) begin
          ramp_next = '0;
          tmr_next = '0;
          oc_hold_next = flags.oc_evt;
          state_next = CPS_ST_OFF;
        end else if (tmr_reg == SS_STEP_LAST) begin
          tmr_next = '0;
          ramp_next = ramp_reg + 1'b1;
          if (ramp_reg == RAMP_FULL - 1'b1) begin
            state_next = CPS_ST_ON;
          end
        end else begin
          tmr_next = tmr_reg + 1'b1;
        end
      end
      CPS_ST_ON: begin
        if (stop_now) begin
          ramp_next = '0;
          tmr_next = '0;
          oc_hold_next = flags.oc_evt;
          state_next = CPS_ST_OFF;
        end
      end
      CPS_ST_OFF: begin
        ramp_next = '0;
        if (oc_hold_reg) begin
          // overcurrent off period runs out before the restart delay
          if (tmr_reg == OC_OFF_LAST) begin
            tmr_next = '0;
            oc_hold_next = 1'b0;
            state_next = CPS_ST_WAIT;
          end else begin
            tmr_next = tmr_reg + 1'b1;
          end
        end else begin
          tmr_next = '0;
          state_next = CPS_ST_WAIT;
        end
      end
      CPS_ST_LOCK: begin
        ramp_next = '0;
        tmr_next = '0;
      end
      default: begin
        ramp_next = '0;
        tmr_next = '0;
        oc_hold_next = 1'b0;
        state_next = CPS_ST_WAIT;
      end
    endcase
    // lockout overrides everything until input power is cycled
    if (|lock_now) begin
      state_next = CPS_ST_LOCK;
      ramp_next = '0;
    end
  end

  // switch enable drops the cycle after a synchronised stop condition
  always_comb begin
    en_next = cps_running(state_next);
    lock_out_next = state_next == CPS_ST_LOCK;
    // a battery overvoltage that still holds the switch off keeps the fault shown
    flt_next = flags.ov || flags.bov_active || flags.oc_active || flags.ot
      || (flags.bov_raw && !cps_running(state_reg))
      || oc_hold_next || (|lock_soon);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= CPS_ST_WAIT;
      tmr_reg <= '0;
      ramp_reg <= '0;
      oc_hold_reg <= 1'b0;
      en_reg <= 1'b0;
      flt_reg <= 1'b0;
      lock_out_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      ramp_reg <= ramp_next;
      oc_hold_reg <= oc_hold_next;
      en_reg <= en_next;
      flt_reg <= flt_next;
      lock_out_reg <= lock_out_next;
    end
  end

  assign switch_en = en_reg;
  assign soft_start_level = ramp_reg;
  assign fault_n_output_o = 1'b0; // open drain: only ever pulls low
  assign fault_n_output_oe = flt_reg;
  assign locked_out = lock_out_reg;
endmodule // cps_sequencer

// ===== sim/cps_sequencer_chk.sv
// port assertions of the charger protection sequencer
`timescale 1ns/100ps
`include "cps_cfg.svh"
module cps_sequencer_chk #(
  parameter int PWRUP_CYC = 50
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic input_ov_comparator,
  input wire logic overcurrent_comparator,
  input wire logic battery_ov_comparator,
  input wire logic overtemp_flag,
  input wire logic switch_en,
  input wire logic [`CPS_RAMP_W-1:0] soft_start_level,
  input wire logic fault_n_output_o,
  input wire logic fault_n_output_oe,
  input wire logic locked_out
);
  int quiet_reg;
  int quiet_next;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // cycles since any flag that must block a start
  always_comb begin
    quiet_next = quiet_reg + 1;
    if (input_ov_comparator || battery_ov_comparator || overtemp_flag) quiet_next = 0;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) quiet_reg <= 0;
    else quiet_reg <= quiet_next;
  end
  // four cycles covers the two sync flops plus state and output registers
  sequence ov_held;
    input_ov_comparator [*4];
  endsequence
  sequence ot_held;
    overtemp_flag [*4];
  endsequence
  a_reset_holds_off: assert property (disable iff (1'b0) !arst_n |-> !switch_en && !fault_n_output_oe)
    else $error("output active in reset");
  a_ov_cut_fast: assert property ($rose(input_ov_comparator) |-> ##[0:4] !switch_en)
    else $error("slow overvoltage cut");
  a_ov_fault_off: assert property (ov_held |=> fault_n_output_oe && !switch_en)
    else $error("overvoltage not flagged");
  a_ot_fault_off: assert property (ot_held |=> fault_n_output_oe && !switch_en)
    else $error("overtemperature not flagged");
  a_start_delayed: assert property ($rose(switch_en) |-> quiet_reg >= PWRUP_CYC)
    else $error("start without full delay");
  a_ramp_from_low: assert property ($rose(switch_en) |-> soft_start_level <= 8'h01)
    else $error("abrupt turn-on");
  a_ramp_rises: assert property (switch_en && $past(switch_en) |-> soft_start_level >= $past(soft_start_level))
    else $error("ramp went down");
  a_drain_low: assert property (fault_n_output_o == 1'b0)
    else $error("open-drain data not low");
  a_lock_holds: assert property (locked_out |-> !switch_en && fault_n_output_oe)
    else $error("lockout not holding");
  a_lock_sticky: assert property (locked_out |=> locked_out)
    else $error("lockout released without reset");
endmodule // cps_sequencer_chk
bind cps_sequencer cps_sequencer_chk #(.PWRUP_CYC(PWRUP_CYC)) u_chk (.clk(clk), .arst_n(arst_n),
  .input_ov_comparator(input_ov_comparator), .overcurrent_comparator(overcurrent_comparator),
  .battery_ov_comparator(battery_ov_comparator), .overtemp_flag(overtemp_flag), .switch_en(switch_en),
  .soft_start_level(soft_start_level), .fault_n_output_o(fault_n_output_o),
  .fault_n_output_oe(fault_n_output_oe), .locked_out(locked_out));

// ===== sim/cps_far_side.sv
// comparator and power path model beside the sequencer
`timescale 1ns/100ps
module cps_far_side (
  input wire logic ov_req,
  input wire logic oc_req,
  input wire logic bov_req,
  input wire logic ot_req,
  input wire logic switch_en,
  output logic input_ov_comparator,
  output logic overcurrent_comparator,
  output logic battery_ov_comparator,
  output logic overtemp_flag
);
  // load current exists only through a conducting switch
  assign overcurrent_comparator = oc_req && switch_en;
  assign input_ov_comparator = ov_req;
  assign battery_ov_comparator = bov_req;
  // hysteresis is analog, so the request already holds it
  assign overtemp_flag = ot_req;
endmodule // cps_far_side

// ===== sim/cps_sequencer_test.sv
// self-checking bench of the charger protection sequencer
`timescale 1ns/100ps
`include "cps_cfg.svh"
module cps_sequencer_test;
  localparam int PU = 50;
  localparam int OFFC = 100;
  localparam int SSC = 512;
  localparam int QUAL = 200;
  localparam int BOVB = 220;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ov_req = 1'b0;
  logic oc_req = 1'b0;
  logic bov_req = 1'b0;
  logic ot_req = 1'b0;
  logic ov_c, oc_c, bov_c, ot_c, sw, f_o, f_oe, lock;
  logic [`CPS_RAMP_W-1:0] lvl;
  int n_fail = 0;
  int checked = 0;
  // 250 MHz
  always #2 clk = ~clk;
  cps_far_side u_far (.ov_req(ov_req), .oc_req(oc_req), .bov_req(bov_req), .ot_req(ot_req), .switch_en(sw),
    .input_ov_comparator(ov_c), .overcurrent_comparator(oc_c), .battery_ov_comparator(bov_c), .overtemp_flag(ot_c));
  cps_sequencer #(.PWRUP_CYC(PU), .OC_OFF_CYC(OFFC), .SS_CYC(SSC), .OC_QUAL_CYC(QUAL), .BOV_BLANK_CYC(BOVB))
    DUT (.clk(clk), .arst_n(arst_n),
    .input_ov_comparator(ov_c), .overcurrent_comparator(oc_c), .battery_ov_comparator(bov_c),
    .overtemp_flag(ot_c), .switch_en(sw), .soft_start_level(lvl), .fault_n_output_o(f_o),
    .fault_n_output_oe(f_oe), .locked_out(lock));
  // inputs always move 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait, so a stuck switch fails instead of hanging
  task automatic wait_sw(input logic v, input int lim);
    for (int i = 0; i < lim && sw !== v; i++) cyc(1);
    chk1("switch_en", v, sw);
  endtask
  task automatic ramp_done();
    cyc(SSC + 10);
    chk8("soft_start_level", 8'hff, lvl);
    chk1("fault_oe", 1'b0, f_oe);
  endtask
  task automatic t_powerup();
    cyc(PU - 5);
    chk1("switch_en", 1'b0, sw);
    wait_sw(1'b1, 40);
    ramp_done();
    $display("test powerup done");
  endtask
  task automatic t_ov();
    ov_req = 1'b1;
    cyc(5);
    chk1("switch_en", 1'b0, sw);
    chk1("fault_oe", 1'b1, f_oe);
    ov_req = 1'b0;
    cyc(PU - 5);
    chk1("switch_en", 1'b0, sw);
    wait_sw(1'b1, 40);
    ramp_done();
    $display("test ov done");
  endtask
  task automatic t_oc();
    oc_req = 1'b1;
    cyc(QUAL - 20);
    oc_req = 1'b0;
    cyc(10);
    chk1("switch_en", 1'b1, sw);
    oc_req = 1'b1;
    cyc(QUAL - 20);
    chk1("switch_en", 1'b1, sw);
    wait_sw(1'b0, 40);
    chk1("fault_oe", 1'b1, f_oe);
    oc_req = 1'b0;
    cyc(OFFC + PU - 10);
    chk1("switch_en", 1'b0, sw);
    wait_sw(1'b1, 60);
    ramp_done();
    $display("test oc done");
  endtask
  task automatic t_bov();
    bov_req = 1'b1;
    cyc(BOVB - 20);
    chk1("fault_oe", 1'b0, f_oe);
    bov_req = 1'b0;
    cyc(10);
    chk1("switch_en", 1'b1, sw);
    $display("test bov done");
  endtask
  task automatic t_ot();
    ot_req = 1'b1;
    cyc(5);
    chk1("switch_en", 1'b0, sw);
    chk1("fault_oe", 1'b1, f_oe);
    cyc(PU + 20);
    chk1("switch_en", 1'b0, sw);
    ot_req = 1'b0;
    wait_sw(1'b1, PU + 40);
    ramp_done();
    $display("test ot done");
  endtask
  task automatic t_por();
    arst_n = 1'b0;
    cyc(2);
    chk1("switch_en", 1'b0, sw);
    chk1("locked_out", 1'b0, lock);
    arst_n = 1'b1;
    t_powerup();
    $display("test por done");
  endtask
  // held overcurrent qualifies again on every restart until the latch trips
  task automatic t_oc_lock();
    oc_req = 1'b1;
    for (int i = 0; i < 14; i++) begin
      wait_sw(1'b0, QUAL + 20);
      wait_sw(1'b1, OFFC + PU + 20);
    end
    chk1("locked_out", 1'b0, lock);
    wait_sw(1'b0, QUAL + 20);
    cyc(2);
    chk1("locked_out", 1'b1, lock);
    chk1("fault_oe", 1'b1, f_oe);
    oc_req = 1'b0;
    cyc(OFFC + PU + 20);
    chk1("switch_en", 1'b0, sw);
    chk1("locked_out", 1'b1, lock);
    $display("test oc lock done");
  endtask
  // battery overvoltage outlasting the blanking, sixteen times
  task automatic t_bov_lock();
    for (int i = 0; i < 16; i++) begin
      bov_req = 1'b1;
      wait_sw(1'b0, BOVB + 20);
      cyc(5);
      chk1("fault_oe", 1'b1, f_oe);
      bov_req = 1'b0;
      if (i < 15) wait_sw(1'b1, PU + 20);
    end
    cyc(2);
    chk1("locked_out", 1'b1, lock);
    cyc(PU + 20);
    chk1("switch_en", 1'b0, sw);
    chk1("fault_oe", 1'b1, f_oe);
    $display("test bov lock done");
  endtask
  task automatic final_report();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    cyc(10);
    chk1("switch_en", 1'b0, sw);
    chk1("fault_oe", 1'b0, f_oe);
    arst_n = 1'b1;
    t_powerup();
    t_ov();
    t_oc();
    t_bov();
    t_ot();
    t_oc_lock();
    t_por();
    t_bov_lock();
    final_report();
  end
  // watchdog about twice the 14k cycles the tests need
  initial begin
    #(30000 * 4);
    n_fail++;
    $display("watchdog expired");
    final_report();
  end
endmodule // cps_sequencer_test
